// ===== xsv_pkg.sv
// Constants for the extended-state enable block and save-area layout.
// Assumes a single core clock; all users refer to names as xsv_pkg::name.
package xsv_pkg;
  // Control register four and identification word bit positions
  localparam int CR4_SAVE_EN_BIT = 18;
  localparam int ID_SUPPORT_BIT = 26;
  localparam int ID_ENABLE_BIT = 27;
  // Enable mask fields
  localparam int MASK_FP_BIT = 0;
  localparam int MASK_VEC_BIT = 1;
  localparam int MASK_WIDE_BIT = 2;
  localparam int MASK_RSVD_LO = 3;
  localparam logic [63:0] MASK_RESET = 64'h0000_0000_0000_0001;
  localparam logic [1:0] MASK_BAD_PAIR = 2'h2;
  // Save-area alignment and region offsets in bytes
  localparam int AREA_ALIGN_BITS = 6;
  localparam logic [9:0] OFF_LEGACY = 10'h000;
  localparam logic [9:0] OFF_VEC_CTRL = 10'h018;
  localparam logic [9:0] OFF_STACK_SLOT = 10'h020;
  localparam logic [9:0] OFF_VEC_SLOT = 10'h0a0;
  localparam logic [9:0] OFF_UNUSED = 10'h1a0;
  localparam logic [9:0] OFF_HEADER = 10'h200;
  localparam logic [9:0] OFF_EXTENDED = 10'h240;
  localparam logic [9:0] LEGACY_BYTES = 10'h200;
  localparam logic [9:0] HEADER_BYTES = 10'h040;
  localparam logic [9:0] BITMAP_BYTES = 10'h008;
  localparam logic [9:0] HDR_RSVD_BYTES = 10'h038;
  localparam int SLOT_SHIFT = 4;
  localparam logic [3:0] STACK_SLOTS = 4'h8;
  localparam logic [4:0] VEC_SLOTS = 5'h10;

  // Instruction classes presented to the block
  typedef enum logic [2:0] {
    XSV_OP_MASK_READ,
    XSV_OP_MASK_WRITE,
    XSV_OP_SAVE,
    XSV_OP_OPT_SAVE,
    XSV_OP_RESTORE,
    XSV_OP_WIDE_VEC,
    XSV_OP_PACKED_VEC,
    XSV_OP_ID_QUERY
  } xsv_op_e;

  // Save-area fields that can be located
  typedef enum logic [2:0] {
    XSV_LAY_FP_CTRL,
    XSV_LAY_VEC_CTRL,
    XSV_LAY_STACK_SLOT,
    XSV_LAY_VEC_SLOT,
    XSV_LAY_UNUSED,
    XSV_LAY_BITMAP,
    XSV_LAY_HDR_RSVD,
    XSV_LAY_EXTENDED
  } xsv_lay_e;
endpackage : xsv_pkg

// ===== xsv_lay_if.sv
// Carrier between the control block and the save-area layout unit.
// Assumes both ends share the core clock.
`timescale 1ns/1ns
interface xsv_lay_if;
  logic req;
  xsv_pkg::xsv_lay_e kind;
  logic [4:0] index;
  logic ack;
  logic error;
  logic [9:0] offset;
  logic [9:0] length;
  modport ctrl (output req, output kind, output index,
    input ack, input error, input offset, input length);
  modport lay (input req, input kind, input index,
    output ack, output error, output offset, output length);
endinterface : xsv_lay_if

// ===== xsv_area_layout.sv
// Save-area layout unit: maps a field kind and slot index to a byte
// offset and length. Assumes synchronous reset copy from the top.
`timescale 1ns/1ns
module xsv_area_layout (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  xsv_lay_if.lay lay
);
  logic [9:0] base;
  logic [9:0] len;
  logic [9:0] slot_off;
  logic bad;

  // Slots are 16 bytes wide, so the index scales by a shift
  assign slot_off = 10'(lay.index) << xsv_pkg::SLOT_SHIFT;

  // Region decode
  always_comb begin
    base = xsv_pkg::OFF_LEGACY;
    len = 10'h018;
    bad = 1'b0;
    unique case (lay.kind)
      xsv_pkg::XSV_LAY_FP_CTRL: begin
        base = xsv_pkg::OFF_LEGACY;
        len = xsv_pkg::OFF_VEC_CTRL;
      end
      xsv_pkg::XSV_LAY_VEC_CTRL: begin
        base = xsv_pkg::OFF_VEC_CTRL;
        len = 10'h008;
      end
      xsv_pkg::XSV_LAY_STACK_SLOT: begin
        base = 10'(xsv_pkg::OFF_STACK_SLOT + slot_off);
        len = 10'h010;
        bad = ({1'b0, lay.index} >= {2'h0, xsv_pkg::STACK_SLOTS});
      end
      xsv_pkg::XSV_LAY_VEC_SLOT: begin
        base = 10'(xsv_pkg::OFF_VEC_SLOT + slot_off);
        len = 10'h010;
        bad = (lay.index >= xsv_pkg::VEC_SLOTS);
      end
      xsv_pkg::XSV_LAY_UNUSED: begin
        base = xsv_pkg::OFF_UNUSED;
        len = 10'(xsv_pkg::LEGACY_BYTES - xsv_pkg::OFF_UNUSED);
      end
      xsv_pkg::XSV_LAY_BITMAP: begin
        base = xsv_pkg::OFF_HEADER;
        len = xsv_pkg::BITMAP_BYTES;
      end
      xsv_pkg::XSV_LAY_HDR_RSVD: begin
        base = 10'(xsv_pkg::OFF_HEADER + xsv_pkg::BITMAP_BYTES);
        len = xsv_pkg::HDR_RSVD_BYTES;
      end
      xsv_pkg::XSV_LAY_EXTENDED: begin
        base = xsv_pkg::OFF_EXTENDED;
        len = 10'h000;
      end
    endcase
  end

  // Answer one cycle after the request
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lay.ack <= 1'b0;
      lay.error <= 1'b0;
      lay.offset <= 10'h000;
      lay.length <= 10'h000;
    end else begin
      lay.ack <= lay.req;
      if (lay.req) begin
        lay.error <= bad;
        lay.offset <= bad ? 10'h000 : base;
        lay.length <= bad ? 10'h000 : len;
      end
    end
  end
endmodule : xsv_area_layout

// ===== xsv_enable_ctrl.sv
// Extended-state enable control: enable mask, fault checks, id mirror
// and save-area layout lookup.
// Assumes requests come from core logic on i_sys_clk, one per cycle.
// Function
// - Save-enable clear faults all five instructions
// - Mask write needs enable and privilege zero
// - Bit zero always one; clear write faults
// - Vector bit resets zero, always settable
// - Packed vector ops never fault here
// - Wide ops need enable plus bits 1,2
// - Wide bit resets zero, needs support
// - Operand bits 2:1 equal 10 fault
// - Reserved mask bits reset to zero
// - Id query bit 27 mirrors enable
// - Mask read returns 64-bit mask
// - Save area base aligned to 64
// - First 512 bytes form legacy region
// - Header 64 bytes at 512, bitmap first
// - Extended region starts at byte 576
// - Stack and vector byte ranges fixed
// - Legacy bytes 511:416 unused
// - 16-byte slots from 32 and 160
// - Enable settable only when supported
`timescale 1ns/1ns
module xsv_enable_ctrl #(
  parameter bit SAVE_SUPPORTED = 1'b1,
  parameter bit WIDE_SUPPORTED = 1'b1,
  parameter bit OPT_SUPPORTED = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_cr4_wr,
  input wire logic [31:0] i_cr4_wdata,
  input wire logic i_instr_valid,
  input wire logic [2:0] i_instr_op,
  input wire logic [1:0] i_cpl,
  input wire logic [63:0] i_operand,
  input wire logic [63:0] i_area_addr,
  input wire logic i_lay_req,
  input wire logic [2:0] i_lay_kind,
  input wire logic [4:0] i_lay_index,
  output logic o_instr_done,
  output logic o_ud_fault,
  output logic o_gp_fault,
  output logic [63:0] o_rd_data,
  output logic [63:0] o_enable_mask,
  output logic o_state_save_enable,
  output logic [31:0] o_id_feature_word,
  output logic o_lay_ack,
  output logic o_lay_error,
  output logic [9:0] o_lay_offset,
  output logic [9:0] o_lay_length
);
  logic rst_meta;
  logic rst_n;
  logic save_en_reg;
  logic save_en_next;
  logic vec_bit_reg;
  logic wide_bit_reg;
  logic [63:0] mask_value;
  xsv_pkg::xsv_op_e op;
  logic is_save_family;
  logic is_area_op;
  logic wr_rsvd_set;
  logic wr_pair_bad;
  logic wr_wide_unsup;
  logic wr_fp_clear;
  logic area_misaligned;
  logic wide_ready;
  logic ud_next;
  logic gp_next;
  logic mask_wr_ok;
  logic [63:0] rd_next;
  logic [31:0] id_word;
  xsv_lay_if lay_bus ();

  // Reset release through two flops; assertion is immediate
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Request decode
  assign op = xsv_pkg::xsv_op_e'(i_instr_op);
  assign is_save_family = (op == xsv_pkg::XSV_OP_MASK_READ) ||
    (op == xsv_pkg::XSV_OP_MASK_WRITE) || is_area_op;
  assign is_area_op = (op == xsv_pkg::XSV_OP_SAVE) ||
    (op == xsv_pkg::XSV_OP_OPT_SAVE) || (op == xsv_pkg::XSV_OP_RESTORE);

  // Mask write operand checks on the proposed value, plus save-area base alignment on i_area_addr
  assign wr_fp_clear = !i_operand[xsv_pkg::MASK_FP_BIT];
  assign wr_pair_bad = (i_operand[2:1] == xsv_pkg::MASK_BAD_PAIR);
  assign wr_wide_unsup = i_operand[xsv_pkg::MASK_WIDE_BIT] &&
    !WIDE_SUPPORTED;
  assign wr_rsvd_set = |i_operand[63:xsv_pkg::MASK_RSVD_LO];
  assign area_misaligned =
    |i_area_addr[xsv_pkg::AREA_ALIGN_BITS-1:0];

  // Wide vector ops need the whole enable chain
  assign wide_ready = save_en_reg && vec_bit_reg && wide_bit_reg;

  // Mask as software sees it; bit zero is hard-wired
  assign mask_value = {61'h0, wide_bit_reg, vec_bit_reg,
    1'b1};

  // Fault selection; undefined opcode outranks protection faults
  always_comb begin
    ud_next = 1'b0;
    gp_next = 1'b0;
    unique case (op)
      xsv_pkg::XSV_OP_MASK_WRITE: begin
        if (!save_en_reg) begin
          ud_next = 1'b1;
        end else begin
          gp_next = (i_cpl != 2'h0) || wr_fp_clear || wr_pair_bad ||
            wr_wide_unsup || wr_rsvd_set;
        end
      end
      xsv_pkg::XSV_OP_OPT_SAVE: begin
        ud_next = !save_en_reg || !OPT_SUPPORTED;
        gp_next = !ud_next && area_misaligned;
      end
      xsv_pkg::XSV_OP_WIDE_VEC: begin
        ud_next = !wide_ready;
      end
      xsv_pkg::XSV_OP_PACKED_VEC: begin
        ud_next = 1'b0;
      end
      xsv_pkg::XSV_OP_ID_QUERY: begin
        ud_next = 1'b0;
      end
      xsv_pkg::XSV_OP_MASK_READ, xsv_pkg::XSV_OP_SAVE,
      xsv_pkg::XSV_OP_RESTORE: begin
        ud_next = is_save_family && !save_en_reg;
        gp_next = !ud_next && is_area_op && area_misaligned;
      end
    endcase
  end

  // A write lands only when no fault was raised
  assign mask_wr_ok = i_instr_valid && (op == xsv_pkg::XSV_OP_MASK_WRITE) &&
    !ud_next && !gp_next;

  // Enable bit follows control register four only if supported
  assign save_en_next = i_cr4_wr ?
    (i_cr4_wdata[xsv_pkg::CR4_SAVE_EN_BIT] && SAVE_SUPPORTED) :
    save_en_reg;

  // Identification word; only support and enable are reported
  assign id_word = ({31'h0, SAVE_SUPPORTED} << xsv_pkg::ID_SUPPORT_BIT) |
    ({31'h0, save_en_reg} << xsv_pkg::ID_ENABLE_BIT);

  // Read data: mask for mask read, id word for id query
  always_comb begin
    rd_next = 64'h0;
    if (op == xsv_pkg::XSV_OP_MASK_READ && save_en_reg) begin
      rd_next = mask_value;
    end else if (op == xsv_pkg::XSV_OP_ID_QUERY) begin
      rd_next = {32'h0, id_word};
    end
  end

  // Control state; mask bits clear from reset
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      save_en_reg <= 1'b0;
      vec_bit_reg <= 1'b0;
      wide_bit_reg <= 1'b0;
    end else begin
      save_en_reg <= save_en_next;
      if (mask_wr_ok) begin
        vec_bit_reg <= i_operand[xsv_pkg::MASK_VEC_BIT];
        wide_bit_reg <= i_operand[xsv_pkg::MASK_WIDE_BIT];
      end
    end
  end

  // Instruction answer, one cycle after the request
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_instr_done <= 1'b0;
      o_ud_fault <= 1'b0;
      o_gp_fault <= 1'b0;
      o_rd_data <= 64'h0;
    end else begin
      o_instr_done <= i_instr_valid;
      o_ud_fault <= i_instr_valid && ud_next;
      o_gp_fault <= i_instr_valid && gp_next;
      if (i_instr_valid) begin
        o_rd_data <= (ud_next || gp_next) ? 64'h0 : rd_next;
      end
    end
  end

  // Status mirrors, registered so that outputs come from flops
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_enable_mask <= xsv_pkg::MASK_RESET;
      o_state_save_enable <= 1'b0;
      o_id_feature_word <= 32'h0;
    end else begin
      o_enable_mask <= mask_value;
      o_state_save_enable <= save_en_reg;
      o_id_feature_word <= id_word;
    end
  end

  // Layout lookups go to the layout unit; its answer is re-registered
  assign lay_bus.req = i_lay_req;
  assign lay_bus.kind = xsv_pkg::xsv_lay_e'(i_lay_kind);
  assign lay_bus.index = i_lay_index;

  xsv_area_layout u_layout (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .lay(lay_bus.lay)
  );

  // Extra stage costs a cycle but keeps outputs flop-driven at the top
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_lay_ack <= 1'b0;
      o_lay_error <= 1'b0;
      o_lay_offset <= 10'h000;
      o_lay_length <= 10'h000;
    end else begin
      o_lay_ack <= lay_bus.ack;
      if (lay_bus.ack) begin
        o_lay_error <= lay_bus.error;
        o_lay_offset <= lay_bus.offset;
        o_lay_length <= lay_bus.length;
      end
    end
  end

  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_req;
    i_instr_valid && op == xsv_pkg::XSV_OP_MASK_WRITE;
  endsequence

  sequence s_lay_answer;
    ##2 o_lay_ack;
  endsequence

  AST_UD_WHEN_DISABLED: assert property (
    i_instr_valid && is_save_family && !save_en_reg |=> o_ud_fault)
    else $error("save family op not faulted while disabled");

  AST_GP_PRIV: assert property (
    s_write_req and (save_en_reg && i_cpl != 2'h0) |=>
      o_gp_fault && !o_ud_fault)
    else $error("mask write above privilege zero not faulted");

  AST_FP_BIT_HELD: assert property (
    s_write_req and (save_en_reg && !i_operand[0]) |=>
      o_gp_fault ##1 o_enable_mask[0])
    else $error("mask write clearing bit zero not refused");

  AST_PACKED_NO_FAULT: assert property (
    i_instr_valid && op == xsv_pkg::XSV_OP_PACKED_VEC |=> !o_ud_fault)
    else $error("packed vector op faulted");

  AST_WIDE_GATE: assert property (
    i_instr_valid && op == xsv_pkg::XSV_OP_WIDE_VEC |=>
      o_ud_fault == !$past(wide_ready))
    else $error("wide op fault mismatch");

  AST_BAD_PAIR: assert property (
    s_write_req and (save_en_reg && i_operand[2:1] == 2'h2) |=> o_gp_fault)
    else $error("bits 2:1 of 10 not faulted");

  AST_RSVD_KEPT: assert property (
    s_write_req and wr_rsvd_set |=> ##1 $stable(o_enable_mask))
    else $error("reserved write changed mask");

  AST_RSVD_ZERO: assert property (
    o_enable_mask[63:3] == 61'h0)
    else $error("reserved mask bits set");

  AST_ID_MIRROR: assert property (
    ##1 o_id_feature_word[27] == $past(save_en_reg))
    else $error("id enable bit not mirrored");

  AST_READ_MASK: assert property (
    i_instr_valid && op == xsv_pkg::XSV_OP_MASK_READ && save_en_reg |=>
      o_rd_data == $past(mask_value) && !o_ud_fault)
    else $error("mask read returned wrong value");

  AST_ENABLE_SUPPORT: assert property (
    i_cr4_wr |=> save_en_reg ==
      ($past(i_cr4_wdata[xsv_pkg::CR4_SAVE_EN_BIT]) && SAVE_SUPPORTED))
    else $error("enable bit does not follow write and support");

  AST_LAY_HEADER: assert property (
    i_lay_req && i_lay_kind == 3'h5 |-> s_lay_answer ##0
      (o_lay_offset == 10'h200 && o_lay_length == 10'h008))
    else $error("header bitmap misplaced");

  AST_LAY_STACK: assert property (
    i_lay_req && i_lay_kind == 3'h2 && i_lay_index < 5'h8 |->
      ##2 o_lay_offset == 10'h020 + {1'b0, $past(i_lay_index, 2), 4'h0})
    else $error("stack slot misplaced");

  AST_LAY_EXT: assert property (
    i_lay_req && i_lay_kind == 3'h7 |-> ##2 o_lay_offset == 10'h240)
    else $error("extended region misplaced");

  AST_ALIGN: assert property (
    i_instr_valid && save_en_reg && is_area_op && area_misaligned &&
      op != xsv_pkg::XSV_OP_OPT_SAVE |=> o_gp_fault)
    else $error("misaligned save area not faulted");

  AST_MASK_LANDS: assert property (
    s_write_req and (save_en_reg && i_cpl == 2'h0 && i_operand[0] &&
      i_operand[63:3] == 61'h0 && i_operand[2:1] != 2'h2 &&
      (WIDE_SUPPORTED || !i_operand[2])) |=>
      ##1 o_enable_mask == {61'h0, $past(i_operand[2:1], 2), 1'b1})
    else $error("legal mask write did not land");

  AST_GP_RSVD: assert property (
    s_write_req and (save_en_reg && i_operand[63:3] != 61'h0) |=> o_gp_fault)
    else $error("reserved mask write not faulted");

  AST_LAY_LEGACY: assert property (
    i_lay_req && i_lay_kind == 3'h0 |-> s_lay_answer ##0
      (o_lay_offset == 10'h000 && o_lay_length == 10'h018))
    else $error("legacy control field misplaced");

  AST_LAY_VEC: assert property (
    i_lay_req && i_lay_kind == 3'h3 && i_lay_index < 5'h10 |->
      ##2 o_lay_offset == 10'h0a0 + {1'b0, $past(i_lay_index, 2), 4'h0})
    else $error("vector slot misplaced");

  AST_LAY_UNUSED: assert property (
    i_lay_req && i_lay_kind == 3'h4 |-> s_lay_answer ##0
      (o_lay_offset == 10'h1a0 && o_lay_length == 10'h060))
    else $error("unused legacy tail misplaced");
endmodule : xsv_enable_ctrl

// ===== tb_xsv_enable_ctrl.sv
// Self-checking bench for the extended-state enable control block.
// Assumes the block answers instructions one cycle after the request
// and layout lookups two cycles after.
`timescale 1ns/1ns
module tb_xsv_enable_ctrl;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_cr4_wr = 1'b0;
  logic [31:0] i_cr4_wdata = 32'h0;
  logic i_instr_valid = 1'b0;
  logic [2:0] i_instr_op = 3'h0;
  logic [1:0] i_cpl = 2'h0;
  logic [63:0] i_operand = 64'h0;
  logic [63:0] i_area_addr = 64'h0;
  logic i_lay_req = 1'b0;
  logic [2:0] i_lay_kind = 3'h0;
  logic [4:0] i_lay_index = 5'h0;
  logic o_instr_done;
  logic o_ud_fault;
  logic o_gp_fault;
  logic [63:0] o_rd_data;
  logic [63:0] o_enable_mask;
  logic o_state_save_enable;
  logic [31:0] o_id_feature_word;
  logic o_lay_ack;
  logic o_lay_error;
  logic [9:0] o_lay_offset;
  logic [9:0] o_lay_length;
  int err_count = 0;
  int num_checks = 0;
  int i;

  // 20 MHz core clock
  always #25 i_sys_clk = ~i_sys_clk;

  xsv_enable_ctrl uut (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_cr4_wr(i_cr4_wr),
    .i_cr4_wdata(i_cr4_wdata),
    .i_instr_valid(i_instr_valid),
    .i_instr_op(i_instr_op),
    .i_cpl(i_cpl),
    .i_operand(i_operand),
    .i_area_addr(i_area_addr),
    .i_lay_req(i_lay_req),
    .i_lay_kind(i_lay_kind),
    .i_lay_index(i_lay_index),
    .o_instr_done(o_instr_done),
    .o_ud_fault(o_ud_fault),
    .o_gp_fault(o_gp_fault),
    .o_rd_data(o_rd_data),
    .o_enable_mask(o_enable_mask),
    .o_state_save_enable(o_state_save_enable),
    .o_id_feature_word(o_id_feature_word),
    .o_lay_ack(o_lay_ack),
    .o_lay_error(o_lay_error),
    .o_lay_offset(o_lay_offset),
    .o_lay_length(o_lay_length)
  );

  // Verdict and end of run, shared by main sequence and watchdog
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // Single-bit result compare; case equality so unknowns fail
  task automatic chk1(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  // Word result compare; narrower values are zero-extended
  task automatic chk64(input string n, input logic [63:0] e,
    input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk64

  // Control register four write; visible on outputs two cycles later
  task automatic cr4_write(input logic [31:0] d);
    @(posedge i_sys_clk);
    i_cr4_wr <= 1'b1;
    i_cr4_wdata <= d;
    @(posedge i_sys_clk);
    i_cr4_wr <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask : cr4_write

  // One instruction request; done and faults stand one cycle only
  task automatic instr(input logic [2:0] op, input logic [1:0] current_privilege_level,
    input logic [63:0] opnd, input logic [63:0] addr,
    input logic eud, input logic egp);
    @(posedge i_sys_clk);
    i_instr_valid <= 1'b1;
    i_instr_op <= op;
    i_cpl <= current_privilege_level;
    i_operand <= opnd;
    i_area_addr <= addr;
    @(posedge i_sys_clk);
    i_instr_valid <= 1'b0;
    #1;
    chk1("done", 1'b1, o_instr_done);
    chk1("ud_fault", eud, o_ud_fault);
    chk1("gp_fault", egp, o_gp_fault);
  endtask : instr

  // Layout lookup; answer lands two edges after the request is taken
  task automatic lay(input logic [2:0] k, input logic [4:0] idx,
    input logic [9:0] eoff, input logic [9:0] elen, input logic eerr);
    @(posedge i_sys_clk);
    i_lay_req <= 1'b1;
    i_lay_kind <= k;
    i_lay_index <= idx;
    @(posedge i_sys_clk);
    i_lay_req <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk1("lay_ack", 1'b1, o_lay_ack);
    chk1("lay_error", eerr, o_lay_error);
    chk64("lay_offset", {54'h0, eoff}, {54'h0, o_lay_offset});
    chk64("lay_length", {54'h0, elen}, {54'h0, o_lay_length});
  endtask : lay

  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    err_count++;
    $display("MISMATCH watchdog expected end seen timeout");
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #1;
    // Reset state: only bit 0 set, feature off, support reported
    chk64("mask", 64'h1, o_enable_mask);
    chk1("wide_rst", 1'b0, o_enable_mask[2]);
    chk1("save_en", 1'b0, o_state_save_enable);
    chk64("id", 64'h0400_0000,
      {32'h0, o_id_feature_word});
    // Feature off: the five save-family ops and wide ops fault
    for (i = 0; i < 5; i++) begin
      instr(i[2:0], 2'h0, 64'h7, 64'h0, 1'b1, 1'b0);
    end
    instr(3'h5, 2'h0, 64'h0, 64'h0, 1'b1, 1'b0);
    instr(3'h6, 2'h3, 64'h0, 64'h0, 1'b0, 1'b0);
    chk64("mask", 64'h1, o_enable_mask);
    instr(3'h7, 2'h3, 64'h0, 64'h0, 1'b0, 1'b0);
    chk64("id_rd", 64'h0400_0000, o_rd_data);
    // Enable the feature, seen in the id word at any privilege
    cr4_write(32'h0004_0000);
    chk1("save_en", 1'b1, o_state_save_enable);
    chk64("id", 64'h0c00_0000,
      {32'h0, o_id_feature_word});
    instr(3'h7, 2'h3, 64'h0, 64'h0, 1'b0, 1'b0);
    chk64("id_rd", 64'h0c00_0000, o_rd_data);
    instr(3'h5, 2'h0, 64'h0, 64'h0, 1'b1, 1'b0);
    // Mask write above privilege zero faults
    for (i = 1; i < 4; i++) begin
      instr(3'h1, i[1:0], 64'h3, 64'h0, 1'b0, 1'b1);
    end
    // Illegal operands: bit 0 clear, bits 2:1 = 10, reserved bits set
    instr(3'h1, 2'h0, 64'h6, 64'h0, 1'b0, 1'b1);
    instr(3'h1, 2'h0, 64'h5, 64'h0, 1'b0, 1'b1);
    instr(3'h1, 2'h0, 64'hb, 64'h0, 1'b0, 1'b1);
    instr(3'h1, 2'h0, 64'h8000_0000_0000_0003, 64'h0, 1'b0, 1'b1);
    instr(3'h1, 2'h0, 64'h0000_0001_0000_0003, 64'h0, 1'b0, 1'b1);
    @(posedge i_sys_clk);
    #1;
    chk64("mask", 64'h1, o_enable_mask);
    // Vector bit alone: accepted, wide ops still refused
    instr(3'h1, 2'h0, 64'h3, 64'h0, 1'b0, 1'b0);
    instr(3'h0, 2'h3, 64'h0, 64'h0, 1'b0, 1'b0);
    chk64("mask_rd", 64'h3, o_rd_data);
    instr(3'h5, 2'h0, 64'h0, 64'h0, 1'b1, 1'b0);
    // Both vector bits: wide ops now run
    instr(3'h1, 2'h0, 64'h7, 64'h0, 1'b0, 1'b0);
    instr(3'h0, 2'h2, 64'h0, 64'h0, 1'b0, 1'b0);
    chk64("mask_rd", 64'h7, o_rd_data);
    instr(3'h5, 2'h3, 64'h0, 64'h0, 1'b0, 1'b0);
    // Save area base: aligned passes, off by 32 bytes faults
    for (i = 2; i < 5; i++) begin
      instr(i[2:0], 2'h0, 64'h7, 64'h1040, 1'b0, 1'b0);
      instr(i[2:0], 2'h0, 64'h7, 64'h1020, 1'b0, 1'b1);
    end
    // Disable again: mask survives but reads fault, packed ops run
    cr4_write(32'h0000_0000);
    chk64("mask", 64'h7, o_enable_mask);
    chk1("save_en", 1'b0, o_state_save_enable);
    instr(3'h0, 2'h0, 64'h0, 64'h0, 1'b1, 1'b0);
    chk64("rd_fault", 64'h0, o_rd_data);
    instr(3'h6, 2'h0, 64'h0, 64'h0, 1'b0, 1'b0);
    instr(3'h5, 2'h0, 64'h0, 64'h0, 1'b1, 1'b0);
    // Save-area layout, slot boundaries and out-of-range indexes
    lay(3'h0, 5'h0, 10'h000, 10'h018, 1'b0);
    lay(3'h1, 5'h0, 10'h018, 10'h008, 1'b0);
    lay(3'h2, 5'h0, 10'h020, 10'h010, 1'b0);
    lay(3'h2, 5'h7, 10'h090, 10'h010, 1'b0);
    lay(3'h2, 5'h8, 10'h000, 10'h000, 1'b1);
    lay(3'h3, 5'h0, 10'h0a0, 10'h010, 1'b0);
    lay(3'h3, 5'hf, 10'h190, 10'h010, 1'b0);
    lay(3'h3, 5'h10, 10'h000, 10'h000, 1'b1);
    lay(3'h4, 5'h0, 10'h1a0, 10'h060, 1'b0);
    lay(3'h5, 5'h0, 10'h200, 10'h008, 1'b0);
    lay(3'h6, 5'h0, 10'h208, 10'h038, 1'b0);
    lay(3'h7, 5'h0, 10'h240, 10'h000, 1'b0);
    wrap_up();
  end
endmodule : tb_xsv_enable_ctrl
